// >>> verilog/mpra_defines.svh
`ifndef MPRA_DEFINES_SVH
`define MPRA_DEFINES_SVH
// ****************************************
// Mode register 3 field positions.
// ****************************************
`define MPRA_MR3_FMT_HI    12
`define MPRA_MR3_FMT_LO    11
`define MPRA_MR3_EN_BIT    2
`define MPRA_MR3_PAGE_HI   1
`define MPRA_MR3_PAGE_LO   0
`define MPRA_MR3_GEAR_BIT  3
// ****************************************
// Page 0 reset patterns.
// ****************************************
`define MPRA_P0_RST0       8'h55
`define MPRA_P0_RST1       8'h33
`define MPRA_P0_RST2       8'h0f
`define MPRA_P0_RST3       8'h00
// ****************************************
// Burst, latency, refresh-mode and vendor figures.
// ****************************************
`define MPRA_BURST_LEN     8
`define MPRA_READ_LAT      4'h4
`define MPRA_REFRESH_1X    2'h1
`define MPRA_VENDOR_NIBBLE 4'h0
`endif

// >>> verilog/mpra_pkg.sv
package mpra_pkg;
    typedef enum logic [3:0] {
        MPRA_CMD_DES, MPRA_CMD_MRS, MPRA_CMD_RD, MPRA_CMD_RDA, MPRA_CMD_WR,
        MPRA_CMD_WRA, MPRA_CMD_REF, MPRA_CMD_ACT, MPRA_CMD_PRE, MPRA_CMD_OTHER
    } mpra_cmd_t;
    typedef enum logic [1:0] {
        MPRA_FMT_SERIAL, MPRA_FMT_PARALLEL, MPRA_FMT_STAGGER, MPRA_FMT_RSVD
    } mpra_fmt_t;
    typedef enum logic {
        MPRA_ST_IDLE, MPRA_ST_BURST
    } mpra_state_t;
endpackage

// >>> verilog/mpra_page0_mem.sv
`include "mpra_defines.svh"
module mpra_page0_mem
    import mpra_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    input  wire logic       i_wr_en,
    input  wire logic [1:0] i_wr_loc,
    input  wire logic [7:0] i_wr_data,
    input  wire logic [1:0] i_rd_loc,
    output logic      [7:0] o_rd_data
);
    logic [7:0] mem_reg  [4];
    logic [7:0] mem_next [4];
    logic [7:0] rd_reg;
    logic [7:0] rd_next;

    // ****************************************
    // Pattern storage with reset defaults.
    // ****************************************
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (i_wr_en) begin
            mem_next[i_wr_loc] = i_wr_data;
        end
        rd_next = mem_reg[i_rd_loc];
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mem_reg[0] <= `MPRA_P0_RST0;
            mem_reg[1] <= `MPRA_P0_RST1;
            mem_reg[2] <= `MPRA_P0_RST2;
            mem_reg[3] <= `MPRA_P0_RST3;
            rd_reg     <= 8'h00;
        end else if (i_ce) begin
            for (int i = 0; i < 4; i++) begin
                mem_reg[i] <= mem_next[i];
            end
            rd_reg <= rd_next;
        end
    end

    assign o_rd_data = rd_reg;
endmodule

// >>> verilog/mpra_access.sv
// What this block does
// - Four pages of four 8-bit locations, read in access mode; only page 0 is written.
// - Page 0 reads in serial or parallel format (staggered and reserved read as serial); pages 1 to 3 serial only.
// - Page 3 is maker data; only location 3 bits 4:3 (refresh mode) are defined.
// - RDA acts as RD and WRA as WR; no auto precharge.
// - Mode register 3 bits 12:11 pick serial, parallel, staggered, reserved.
// - Mode register 3 bit 2 enables the access mode.
// - Mode register 3 bits 1:0 pick the page.
// - Bit n is written from address n and read in interval 7 minus n.
// - Bank address picks the location; page 0 has fixed reset patterns.
// - Refresh-mode code: 00 sub-1X, 01 1X, 10 2X, 11 reserved.
// - Serial format drives the same pattern on every lane.
// - Parallel format repeats location 0 across lanes every interval.
// - Written page 0 values persist until reset restores defaults.
`include "mpra_defines.svh"
module mpra_access
    import mpra_pkg::*;
#(
    parameter int DQ_WIDTH = 8
)(
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_ce,
    input  wire logic [3:0]          i_cmd,
    input  wire logic [17:0]         i_addr,
    input  wire logic [1:0]          i_ba,
    input  wire logic                i_err_capture,
    input  wire logic [27:0]         i_err_frame,
    input  wire logic                i_crc_err,
    input  wire logic                i_par_err,
    input  wire logic [2:0]          i_par_lat,
    input  wire logic [7:0]          i_cas_lat,
    input  wire logic [2:0]          i_wr_lat,
    input  wire logic [1:0]          i_rtt_wr,
    input  wire logic [2:0]          i_rtt_nom,
    input  wire logic [2:0]          i_rtt_park,
    input  wire logic [1:0]          i_drv_str,
    input  wire logic [6:0]          i_vref_val,
    input  wire logic [1:0]          i_ppr_sup,
    input  wire logic [1:0]          i_refresh_mode,
    output logic                     o_mode_en,
    output logic [1:0]               o_page,
    output logic [1:0]               o_fmt,
    output logic                     o_cmd_illegal,
    output logic                     o_dq_oe,
    output logic [DQ_WIDTH-1:0]      o_dq
);
    if (DQ_WIDTH != 4 && DQ_WIDTH != 8 && DQ_WIDTH != 16) begin : g_bad_width
        $error("DQ_WIDTH must be 4, 8 or 16.");
    end

    mpra_state_t     state_reg, state_next;
    logic            en_reg, en_next;
    logic            gear_reg, gear_next;
    logic [1:0]      page_reg, page_next;
    logic [1:0]      fmt_reg, fmt_next;
    logic [3:0]      lat_reg, lat_next;
    logic [2:0]      ui_reg, ui_next;
    logic [1:0]      loc_reg, loc_next;
    logic [7:0]      pat_reg, pat_next;
    logic [1:0]      rd_page_reg, rd_page_next;
    logic            ill_reg, ill_next;
    logic [31:0]     err_reg, err_next;
    logic [DQ_WIDTH-1:0] dq_reg, dq_next;
    logic            oe_reg, oe_next;
    logic [7:0]      p0_data;
    logic [7:0]      loc_byte;
    logic            is_rd;
    logic            is_wr;
    mpra_cmd_t       cmd;

    assign cmd   = mpra_cmd_t'(i_cmd);
    assign is_rd = (cmd == MPRA_CMD_RD) || (cmd == MPRA_CMD_RDA);
    assign is_wr = (cmd == MPRA_CMD_WR) || (cmd == MPRA_CMD_WRA);

    mpra_page0_mem u_page0 (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_wr_en   (en_reg && is_wr && page_reg == 2'h0),
        .i_wr_loc  (i_ba),
        .i_wr_data (i_addr[7:0]),
        .i_rd_loc  ((fmt_reg == 2'(MPRA_FMT_PARALLEL)) ? 2'h0 : loc_reg),
        .o_rd_data (p0_data)
    );

    // ****************************************
    // Byte selection for all four pages.
    // ****************************************
    always_comb begin
        loc_byte = 8'h00;
        unique case (rd_page_reg)
            2'h0: loc_byte = p0_data;
            2'h1: loc_byte = err_reg[8*loc_reg +: 8];
            2'h2: begin
                unique case (loc_reg)
                    2'h0: loc_byte = {i_ppr_sup, 1'b0, 1'b0, 1'b0, 1'b0, i_rtt_wr};
                    2'h1: loc_byte = {i_vref_val, gear_reg};
                    2'h2: loc_byte = {i_cas_lat[4:0], i_wr_lat};
                    2'h3: loc_byte = {i_rtt_nom, i_rtt_park, i_drv_str};
                endcase
            end
            2'h3: begin
                loc_byte = (loc_reg == 2'h3) ? {3'h0, i_refresh_mode, 3'h0} : 8'h00;
            end
        endcase
    end

    // ****************************************
    // Mode control, error log and readout.
    // ****************************************
    always_comb begin
        state_next   = state_reg;
        en_next      = en_reg;
        gear_next    = gear_reg;
        page_next    = page_reg;
        fmt_next     = fmt_reg;
        lat_next     = lat_reg;
        ui_next      = ui_reg;
        loc_next     = loc_reg;
        pat_next     = pat_reg;
        rd_page_next = rd_page_reg;
        ill_next     = 1'b0;
        err_next     = err_reg;
        dq_next      = dq_reg;
        oe_next      = 1'b0;
        if (i_err_capture) begin
            err_next = {i_crc_err, i_par_err, i_par_lat[1:0], 4'h0, i_err_frame[27:20],
                        i_err_frame[15:8], i_err_frame[7:0]};
            err_next[31:29] = {i_crc_err, i_par_err, i_par_lat[2]};
            err_next[28:24] = {i_par_lat[1:0], 3'h0};
        end
        if (cmd == MPRA_CMD_MRS) begin
            en_next   = i_addr[`MPRA_MR3_EN_BIT];
            gear_next = i_addr[`MPRA_MR3_GEAR_BIT];
            page_next = i_addr[`MPRA_MR3_PAGE_HI:`MPRA_MR3_PAGE_LO];
            fmt_next  = i_addr[`MPRA_MR3_FMT_HI:`MPRA_MR3_FMT_LO];
        end
        if (en_reg && !(cmd inside {MPRA_CMD_DES, MPRA_CMD_MRS, MPRA_CMD_RD,
                    MPRA_CMD_RDA, MPRA_CMD_WR, MPRA_CMD_WRA, MPRA_CMD_REF})) begin
            ill_next = 1'b1;
        end
        unique case (state_reg)
            MPRA_ST_IDLE: begin
                if (en_reg && is_rd) begin
                    state_next   = MPRA_ST_BURST;
                    lat_next     = `MPRA_READ_LAT;
                    ui_next      = 3'h0;
                    loc_next     = i_ba;
                    rd_page_next = page_reg;
                end
            end
            MPRA_ST_BURST: begin
                if (lat_reg > 4'h1) begin
                    lat_next = lat_reg - 4'h1;
                end else if (lat_reg == 4'h1) begin
                    lat_next = 4'h0;
                    pat_next = loc_byte;
                end else begin
                    oe_next = 1'b1;
                    for (int b = 0; b < DQ_WIDTH; b++) begin
                        if (fmt_reg == 2'(MPRA_FMT_PARALLEL) && rd_page_reg == 2'h0) begin
                            dq_next[b] = pat_reg[7 - (b % 8)];
                        end else begin
                            dq_next[b] = pat_reg[3'h7 - ui_reg];
                        end
                    end
                    ui_next = ui_reg + 3'h1;
                    if (ui_reg == 3'h7) begin
                        state_next = MPRA_ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_reg   <= MPRA_ST_IDLE;
            en_reg      <= 1'b0;
            gear_reg    <= 1'b0;
            page_reg    <= 2'h0;
            fmt_reg     <= 2'h0;
            lat_reg     <= 4'h0;
            ui_reg      <= 3'h0;
            loc_reg     <= 2'h0;
            pat_reg     <= 8'h00;
            rd_page_reg <= 2'h0;
            ill_reg     <= 1'b0;
            err_reg     <= 32'h0;
            dq_reg      <= '0;
            oe_reg      <= 1'b0;
        end else if (i_ce) begin
            state_reg   <= state_next;
            en_reg      <= en_next;
            gear_reg    <= gear_next;
            page_reg    <= page_next;
            fmt_reg     <= fmt_next;
            lat_reg     <= lat_next;
            ui_reg      <= ui_next;
            loc_reg     <= loc_next;
            pat_reg     <= pat_next;
            rd_page_reg <= rd_page_next;
            ill_reg     <= ill_next;
            err_reg     <= err_next;
            dq_reg      <= dq_next;
            oe_reg      <= oe_next;
        end
    end

    assign o_mode_en     = en_reg;
    assign o_page        = page_reg;
    assign o_fmt         = fmt_reg;
    assign o_cmd_illegal = ill_reg;
    assign o_dq_oe       = oe_reg;
    assign o_dq          = dq_reg;
endmodule

// >>> testbench/mpra_access_props.sv
module mpra_access_props
    import mpra_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    input wire logic [3:0]  i_cmd,
    input wire logic [17:0] i_addr,
    input wire logic        o_mode_en,
    input wire logic [1:0]  o_page,
    input wire logic [1:0]  o_fmt,
    input wire logic        o_cmd_illegal,
    input wire logic        o_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence mrs_s;
        i_ce && i_cmd == MPRA_CMD_MRS;
    endsequence
    sequence burst_s;
        o_dq_oe [*8] ##1 !o_dq_oe;
    endsequence
    AST_MRS_EN: assert property (mrs_s |=> o_mode_en == $past(i_addr[2]))
        else $error("enable bit not taken from mode set");
    AST_MRS_PAGE: assert property (mrs_s |=> o_page == $past(i_addr[1:0]))
        else $error("page not taken from mode set");
    AST_MRS_FMT: assert property (mrs_s |=> o_fmt == $past(i_addr[12:11]))
        else $error("format not taken from mode set");
    AST_MODE_HOLD: assert property (!(i_ce && i_cmd == MPRA_CMD_MRS) |=>
        $stable({o_mode_en, o_page, o_fmt}))
        else $error("mode changed without mode set");
    AST_ILLEGAL: assert property (i_ce && o_mode_en && i_cmd inside {MPRA_CMD_ACT,
        MPRA_CMD_PRE, MPRA_CMD_OTHER} |=> o_cmd_illegal)
        else $error("disallowed command not flagged");
    AST_LEGAL: assert property (i_ce && i_cmd <= MPRA_CMD_REF |=> !o_cmd_illegal)
        else $error("allowed command flagged");
    AST_READ_LAT: assert property ($rose(o_dq_oe) |-> $past(o_mode_en, 6) &&
        ($past(i_cmd, 6) == MPRA_CMD_RD || $past(i_cmd, 6) == MPRA_CMD_RDA))
        else $error("burst without read six cycles before");
    AST_BURST: assert property ($rose(o_dq_oe) |-> burst_s)
        else $error("burst not eight intervals");
endmodule

// >>> testbench/mpra_ctrl_model.sv
module mpra_ctrl_model
    import mpra_pkg::*;
(
    input  wire logic        i_clk,
    output logic      [3:0]  o_cmd,
    output logic      [17:0] o_addr,
    output logic      [1:0]  o_ba
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_cmd  = MPRA_CMD_DES;
        o_addr = 18'h0;
        o_ba   = 2'h0;
    end
    // One command for one cycle, then deselect with the pins inverted.
    task automatic issue(input mpra_cmd_t c, input logic [17:0] a, input logic [1:0] b);
        @(negedge i_clk);
        o_cmd  = c;
        o_addr = a;
        o_ba   = b;
        @(negedge i_clk);
        o_cmd  = MPRA_CMD_DES;
        o_addr = ~a;
        o_ba   = ~b;
    endtask
    task automatic mrs(input logic [1:0] f, input logic en, input logic [1:0] pg);
        issue(MPRA_CMD_MRS, {5'h00, f, 8'h00, en, pg}, 2'h0);
    endtask
endmodule

// >>> testbench/mpra_access_test.sv
module mpra_access_test
    import mpra_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_rst_n, i_ce, i_err_capture, o_mode_en, o_cmd_illegal, o_dq_oe;
    logic [27:0] i_err_frame;
    logic [34:0] misc;
    logic [1:0]  i_refresh_mode, i_ba, o_page, o_fmt;
    logic [3:0]  i_cmd;
    logic [17:0] i_addr;
    logic [7:0]  o_dq, pat [4];
    logic [31:0] seed;
    logic [15:0] exp_q [$];
    logic [15:0] e;
    int          n_errors, num_checks;
    mpra_access #(.DQ_WIDTH(8)) mpra_access_inst (.i_clk, .i_rst_n, .i_ce, .i_cmd, .i_addr,
        .i_ba, .i_err_capture, .i_err_frame, .i_crc_err(misc[0]), .i_par_err(misc[1]),
        .i_par_lat(misc[4:2]), .i_cas_lat(misc[12:5]), .i_wr_lat(misc[15:13]),
        .i_rtt_wr(misc[17:16]), .i_rtt_nom(misc[20:18]), .i_rtt_park(misc[23:21]),
        .i_drv_str(misc[25:24]), .i_vref_val(misc[32:26]), .i_ppr_sup(misc[34:33]),
        .i_refresh_mode, .o_mode_en, .o_page, .o_fmt, .o_cmd_illegal, .o_dq_oe, .o_dq);
    mpra_ctrl_model ctrl_inst (.i_clk, .o_cmd(i_cmd), .o_addr(i_addr), .o_ba(i_ba));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7-i];
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Notes eight lane words per read, then waits out the burst before the next command.
    task automatic rd(input mpra_cmd_t c, input logic [1:0] loc, input logic [7:0] b,
                      input logic [7:0] m, input logic par);
        for (int k = 0; k < 8; k++)
            exp_q.push_back(par ? {8'hff, rev(b)} : {{8{m[7-k]}}, {8{b[7-k]}}});
        ctrl_inst.issue(c, 18'h0, loc);
        repeat (14) @(negedge i_clk);
        for (int t = 0; t < 20 && exp_q.size() != 0; t++) @(negedge i_clk);
        if (exp_q.size() != 0) begin
            n_errors++;
            finish_test();
        end
    endtask
    always @(negedge i_clk) begin
        if (o_dq_oe === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(8'h00, 8'hff);
            end else begin
                e = exp_q.pop_front();
                check(o_dq & e[15:8], e[7:0] & e[15:8]);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        finish_test();
    end
    initial begin
        seed = 32'hd7177cce;
        misc = 35'h0;
        {i_err_capture, i_err_frame, i_refresh_mode} = '0;
        pat = '{8'h55, 8'h33, 8'h0f, 8'h00};
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        repeat (10) @(negedge i_clk);
        check({1'b0, o_mode_en, o_dq_oe, o_cmd_illegal, o_page, o_fmt}, 8'h00);
        i_rst_n = 1'b1;
        ctrl_inst.mrs(2'h0, 1'b1, 2'h0);
        for (int l = 0; l < 4; l++) rd(MPRA_CMD_RD, 2'(l), pat[l], 8'hff, 1'b0);
        $display("defaults done");
        for (int l = 0; l < 4; l++) begin
            seed = lfsr(seed);
            pat[l] = seed[7:0];
            ctrl_inst.issue(l[0] ? MPRA_CMD_WRA : MPRA_CMD_WR, {10'h0, pat[l]}, 2'(l));
        end
        for (int l = 0; l < 4; l++) rd(MPRA_CMD_RDA, 2'(l), pat[l], 8'hff, 1'b0);
        ctrl_inst.mrs(2'h1, 1'b1, 2'h0);
        rd(MPRA_CMD_RD, 2'h0, pat[0], 8'hff, 1'b1);
        ctrl_inst.mrs(2'h2, 1'b1, 2'h0);
        rd(MPRA_CMD_RD, 2'h1, pat[1], 8'hff, 1'b0);
        ctrl_inst.mrs(2'h3, 1'b1, 2'h0);
        $display("page 0 done");
        seed = lfsr(seed);
        misc = {seed, seed[2:0]};
        i_err_frame = seed[27:0];
        i_err_capture = 1'b1;
        @(negedge i_clk);
        i_err_capture = 1'b0;
        ctrl_inst.mrs(2'h0, 1'b1, 2'h1);
        ctrl_inst.issue(MPRA_CMD_WR, 18'h0a5, 2'h0);
        rd(MPRA_CMD_RD, 2'h0, i_err_frame[7:0], 8'hff, 1'b0);
        rd(MPRA_CMD_RD, 2'h2, i_err_frame[27:20], 8'hff, 1'b0);
        rd(MPRA_CMD_RD, 2'h3, {misc[0], misc[1], misc[4:2], 3'h0}, 8'hf8, 1'b0);
        ctrl_inst.mrs(2'h0, 1'b1, 2'h2);
        rd(MPRA_CMD_RD, 2'h2, {misc[9:5], misc[15:13]}, 8'hff, 1'b0);
        ctrl_inst.issue(MPRA_CMD_MRS, 18'h0000e, 2'h0);
        rd(MPRA_CMD_RD, 2'h1, {misc[32:26], 1'b1}, 8'hff, 1'b0);
        for (int r = 0; r < 4; r++) begin
            i_refresh_mode = 2'(r);
            ctrl_inst.mrs(2'h0, 1'b1, 2'h3);
            rd(MPRA_CMD_RD, 2'h3, {3'h0, 2'(r), 3'h0}, 8'h18, 1'b0);
        end
        $display("pages 1 to 3 done");
        for (int i = 1; i < 4; i++) begin
            ctrl_inst.issue(mpra_cmd_t'(4'h6 + 4'(i)), 18'h0, 2'h0);
            check({7'h0, o_cmd_illegal}, 8'h01);
        end
        ctrl_inst.issue(MPRA_CMD_REF, 18'h0, 2'h0);
        check({7'h0, o_cmd_illegal}, 8'h00);
        repeat (20) @(negedge i_clk);
        i_ce = 1'b0;
        ctrl_inst.mrs(2'h0, 1'b0, 2'h0);
        i_ce = 1'b1;
        check({7'h0, o_mode_en}, 8'h01);
        ctrl_inst.mrs(2'h0, 1'b0, 2'h0);
        ctrl_inst.issue(MPRA_CMD_RD, 18'h0, 2'h0);
        repeat (14) @(negedge i_clk);
        $display("commands done");
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        ctrl_inst.mrs(2'h0, 1'b1, 2'h0);
        rd(MPRA_CMD_RD, 2'h0, 8'h55, 8'hff, 1'b0);
        $display("reset done");
        finish_test();
    end
endmodule
bind mpra_access mpra_access_props props_inst (.i_clk, .i_rst_n, .i_ce, .i_cmd, .i_addr,
    .o_mode_en, .o_page, .o_fmt, .o_cmd_illegal, .o_dq_oe);
